// File: bench/asrbt_sram_model.sv
`timescale 1ns/1ps
module asrbt_sram_model
  (
  input wire asrbt_pkg::asrbt_pins_t pins,
  input wire logic [asrbt_pkg::DATA_W-1:0] bus,
  input wire logic slow,
  output logic [asrbt_pkg::DATA_W-1:0] dq,
  output logic driving,
  output int err_count
  );
  logic [15:0] mem [logic [19:0]]; // Stored words
  time t_fall; // Strobe fall time
  time t_data; // Last data change under strobe
  wire sel = !pins.chip_select_n && pins.chip_select_high_active;
  wire [15:0] lmask = {{8{!pins.upper_lane_select_n}}, {8{!pins.lower_lane_select_n}}};
  // Unwritten places read as inverted address
  function automatic logic [15:0] lookup(input logic [19:0] a);
    return mem.exists(a) ? mem[a] : ~a[15:0];
  endfunction
  initial
  begin
    dq = 16'h5a5a;
    driving = 1'h0;
    err_count = 0;
    t_fall = 0;
    t_data = 0;
  end
  // Read drive; released pins show the inverse of their last value
  always @(pins)
  begin
    driving = sel && !pins.output_enable_n && pins.write_strobe_n && lmask != 16'h0;
    if (pins.write_strobe_n)
      dq = ~dq;
    if (driving)
    begin
      // Data shows only after the worst-case access time
      #(slow ? asrbt_pkg::ADDR_TO_DATA_DELAY_S_NS : asrbt_pkg::ADDR_TO_DATA_DELAY_F_NS);
      if (driving)
        dq = (lookup(pins.addr) & lmask) | (~dq & ~lmask);
    end
  end
  // Strobe fall opens a data setup window
  always @(negedge pins.write_strobe_n)
  begin
    t_fall = $time;
    t_data = $time;
  end
  always @(bus)
    if (!pins.write_strobe_n)
      t_data = $time;
  // End of write: check pulse and setup, store chosen lanes
  always @(posedge pins.write_strobe_n)
    if (sel && lmask != 16'h0)
    begin
      if ($time - t_fall < (slow ? asrbt_pkg::STROBE_WIDTH_S_NS : asrbt_pkg::STROBE_WIDTH_F_NS))
        err_count++;
      if ($time - t_data < (slow ? asrbt_pkg::DATA_OVERLAP_MIN_S_NS :
        asrbt_pkg::DATA_OVERLAP_MIN_F_NS))
        err_count++;
      mem[pins.addr] = (bus & lmask) | (lookup(pins.addr) & ~lmask);
    end
endmodule

// File: bench/async_sram_bus_timing_bench.sv
`timescale 1ns/1ps
module async_sram_bus_timing_bench;
  logic sys_clk;
  logic reset_n;
  logic req_valid;
  asrbt_pkg::asrbt_req_t req;
  logic req_ready;
  logic rsp_valid;
  logic [15:0] rsp_rdata;
  logic retention_req;
  logic retention_active;
  asrbt_pkg::asrbt_pins_t pins;
  logic [15:0] bus_out;
  logic [15:0] bus_oe_n;
  logic [15:0] dq;
  logic [15:0] bus;
  logic driving;
  logic slow;
  int model_errs;
  int fail_count;
  int samples_checked;
  int seed;
  logic [15:0] ref_mem [logic [19:0]]; // Expected contents
  logic armed; // Watching for first access after retention
  time t_sel;
  // Wire level: host where it drives, else memory side
  assign bus = (bus_out & ~bus_oe_n) | (dq & bus_oe_n);
  asrbt_host #(.SPEED_GRADE(asrbt_pkg::GRADE_FAST)) i_asrbt_host (.sys_clk(sys_clk),
    .reset_n(reset_n), .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .retention_req(retention_req),
    .retention_active(retention_active), .pins(pins), .shared_data_bus_in(bus),
    .shared_data_bus_out(bus_out), .shared_data_bus_oe_n(bus_oe_n));
  asrbt_sram_model i_asrbt_sram_model (.pins(pins), .bus(bus), .slow(slow), .dq(dq),
    .driving(driving), .err_count(model_errs));
  initial
  begin
    sys_clk = 1'h0;
    forever #4 sys_clk = ~sys_clk;
  end
  function automatic logic [15:0] mask(input logic [1:0] ln);
    return {{8{ln[1]}}, {8{ln[0]}}};
  endfunction
  function automatic logic [15:0] exp_word(input logic [19:0] a);
    return ref_mem.exists(a) ? ref_mem[a] : ~a[15:0];
  endfunction
  task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED at %0t: read %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_bit(input logic ok, input string what);
    samples_checked++;
    if (ok !== 1'h1)
    begin
      fail_count++;
      $display("CHECK FAILED at %0t: %s", $time, what);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // One request held until taken; reads wait for the answer
  task automatic issue(input logic w, input logic [19:0] a, input logic [15:0] d,
    input logic [1:0] ln);
    int n;
    n = 0;
    req_valid <= 1'h1;
    req <= '{write: w, addr: a, wdata: d, lanes: ln};
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (req_ready !== 1'h1 && n < 200);
    check_bit(n < 200, "request never taken");
    req_valid <= 1'h0;
    if (!w)
    begin
      do
      begin
        @(posedge sys_clk);
        n++;
      end
      while (rsp_valid !== 1'h1 && n < 400);
      check_bit(rsp_valid === 1'h1, "no read answer");
      check_word(rsp_rdata & mask(ln), exp_word(a) & mask(ln));
    end
    else
      ref_mem[a] = (d & mask(ln)) | (exp_word(a) & ~mask(ln));
    @(posedge sys_clk);
  endtask
  // Every edge: no contention, strobe high while reading
  always @(posedge sys_clk)
    if (reset_n)
    begin
      check_bit(!(driving && bus_oe_n !== 16'hffff), "bus contention");
      check_bit(pins.output_enable_n || pins.write_strobe_n, "strobe low in read");
      if (armed && !pins.chip_select_n && pins.chip_select_high_active)
      begin
        armed = 1'h0;
        t_sel = $time;
      end
    end
  initial
  begin
    #100000;
    fail_count++;
    close_out;
  end
  initial
  begin
    logic [31:0] r;
    time t_rec;
    int n;
    seed = 32'headc2d51;
    reset_n = 1'h0;
    req_valid = 1'h0;
    req = '0;
    retention_req = 1'h0;
    slow = 1'h0;
    armed = 1'h0;
    t_sel = 0;
    fail_count = 0;
    samples_checked = 0;
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'h1;
    @(posedge sys_clk);
    #1 check_bit(pins.chip_select_n && pins.write_strobe_n && bus_oe_n === 16'hffff, "idle");
    @(posedge sys_clk);
    issue(1'h1, 20'h00000, 16'h1234, 2'h3);
    issue(1'h0, 20'h00000, 16'h0000, 2'h3);
    issue(1'h1, 20'hfffff, 16'habcd, 2'h2);
    issue(1'h0, 20'hfffff, 16'h0000, 2'h3);
    issue(1'h1, 20'hfffff, 16'h5555, 2'h0);
    issue(1'h0, 20'hfffff, 16'h0000, 2'h1);
    repeat (60)
    begin
      r = $random(seed);
      issue(r[0], r[1] ? {20{r[2]}} : {17'h0, r[5:3]}, r[31:16], {r[7], r[6] | ~r[7]});
    end
    retention_req <= 1'h1;
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (retention_active !== 1'h1 && n < 50);
    check_bit(retention_active === 1'h1, "no retention entry");
    check_bit(pins.chip_select_n || !pins.chip_select_high_active, "selected in retention");
    retention_req <= 1'h0;
    t_rec = $time;
    armed = 1'h1;
    issue(1'h0, 20'h00000, 16'h0000, 2'h3);
    check_bit(t_sel > t_rec && t_sel - t_rec >= asrbt_pkg::READ_PERIOD_MIN_F_NS,
      "early access");
    check_bit(model_errs == 0, "write timing at memory");
    close_out;
  end
endmodule

// File: core/asrbt_host.sv
`timescale 1ns/1ps
// Functional notes
// - Write only with both selects, strobe, lane
// - Write strobe stays high during reads
// - Address stable before selects assert
// - Address, selects held; write period respected
// - Lane selects held through write pulse
// - Write data valid before and after end
// - Output enable high during writes
// - No write drive while memory drives
module asrbt_host
  #(
  parameter logic SPEED_GRADE = asrbt_pkg::GRADE_FAST
  )
  (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic req_valid,
  input wire asrbt_pkg::asrbt_req_t req,
  output logic req_ready,
  output logic rsp_valid,
  output logic [asrbt_pkg::DATA_W-1:0] rsp_rdata,
  input wire logic retention_req,
  output logic retention_active,
  output asrbt_pkg::asrbt_pins_t pins,
  input wire logic [asrbt_pkg::DATA_W-1:0] shared_data_bus_in,
  output logic [asrbt_pkg::DATA_W-1:0] shared_data_bus_out,
  output logic [asrbt_pkg::DATA_W-1:0] shared_data_bus_oe_n
  );

  // Grade-dependent cycle counts
  localparam logic [3:0] READ_CYC = 4'((SPEED_GRADE == asrbt_pkg::GRADE_SLOW) ?
    asrbt_pkg::READ_CYC_S : asrbt_pkg::READ_CYC_F);
  localparam logic [3:0] STROBE_CYC = 4'((SPEED_GRADE == asrbt_pkg::GRADE_SLOW) ?
    asrbt_pkg::STROBE_CYC_S : asrbt_pkg::STROBE_CYC_F);
  localparam logic [3:0] WRITE_CYC = 4'((SPEED_GRADE == asrbt_pkg::GRADE_SLOW) ?
    asrbt_pkg::WRITE_CYC_S : asrbt_pkg::WRITE_CYC_F);
  localparam logic [3:0] FLOAT_CYC = 4'((SPEED_GRADE == asrbt_pkg::GRADE_SLOW) ?
    asrbt_pkg::FLOAT_CYC_S : asrbt_pkg::FLOAT_CYC_F);

  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE, ST_SETUP, ST_READ, ST_TURN, ST_WSETUP, ST_WPULSE, ST_WEND, ST_RETAIN
  } asrbt_state_t;

  asrbt_state_t state; // Current state
  asrbt_state_t next_state; // Next state
  asrbt_pkg::asrbt_req_t held; // Latched request
  logic [asrbt_pkg::DATA_W-1:0] sync1; // Data bus synchroniser, first stage
  logic [asrbt_pkg::DATA_W-1:0] sync2; // Data bus synchroniser, second stage
  logic ret_s1; // Retention request, first stage
  logic ret_s2; // Retention request, second stage
  logic t_load; // Timer load pulse
  logic [3:0] t_value; // Timer load value
  logic t_done; // Timer expired
  logic sample_cnt; // Extra cycle for synchroniser latency
  logic next_sample_cnt; // Next sample counter

  // Shared countdown timer
  asrbt_timer u_timer
    (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .load(t_load),
    .value(t_value),
    .done(t_done)
    );

  // Decoded conditions
  // Taken only while ready is shown, so a shown ready always means taken
  wire take_req = (state == ST_IDLE) && req_valid && req_ready;
  wire go_retain = (state == ST_IDLE) && ret_s2;

  // Timer loads on state entry
  always_comb
  begin
    t_load = 1'b0;
    t_value = '0;
    next_state = state;
    next_sample_cnt = sample_cnt;
    unique case (state)
      ST_IDLE:
      begin
        // A request already shown as taken wins over retention
        if (take_req)
          next_state = ST_SETUP;
        else if (go_retain)
        begin
          t_load = 1'b1;
          t_value = READ_CYC;
          next_state = ST_RETAIN;
        end
      end
      ST_SETUP:
      begin
        // Address settles one cycle before selects
        t_load = 1'b1;
        t_value = held.write ? FLOAT_CYC : READ_CYC;
        next_sample_cnt = 1'b0;
        next_state = held.write ? ST_TURN : ST_READ;
      end
      ST_READ:
      begin
        // Wait full access, then two synchroniser cycles
        if (t_done)
        begin
          next_sample_cnt = 1'b1;
          if (sample_cnt)
            next_state = ST_IDLE;
        end
      end
      ST_TURN:
      begin
        // Let any previous read drivers float
        if (t_done)
          next_state = ST_WSETUP;
      end
      ST_WSETUP:
      begin
        t_load = 1'b1;
        t_value = STROBE_CYC;
        next_state = ST_WPULSE;
      end
      ST_WPULSE:
      begin
        if (t_done)
          next_state = ST_WEND;
      end
      ST_WEND:
      begin
        next_state = ST_IDLE;
      end
      ST_RETAIN:
      begin
        // Timer kept full while supply is low, then a read period of recovery
        if (ret_s2)
        begin
          t_load = 1'b1;
          t_value = READ_CYC;
        end
        else if (t_done)
          next_state = ST_IDLE;
      end
    endcase
  end

  // State, request latch and synchronisers
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      state <= ST_IDLE;
      held <= '0;
      sync1 <= '0;
      sync2 <= '0;
      ret_s1 <= 1'b0;
      ret_s2 <= 1'b0;
      sample_cnt <= 1'b0;
    end
    else
    begin
      state <= next_state;
      if (take_req)
        held <= req;
      sync1 <= shared_data_bus_in;
      sync2 <= sync1;
      ret_s1 <= retention_req;
      ret_s2 <= ret_s1;
      sample_cnt <= next_sample_cnt;
    end
  end

  // Pin decode for the coming state; selects and lanes stay on through WEND
  // so that the strobe rises while the write is still fully selected
  wire sel_on = (next_state == ST_READ) || (next_state == ST_TURN)
    || (next_state == ST_WSETUP) || (next_state == ST_WPULSE) || (next_state == ST_WEND);
  wire rd_on = (next_state == ST_READ);
  // No strobe without a lane: an empty lane mask is a no-op write
  wire wr_on = (next_state == ST_WPULSE) && (held.lanes != 2'h0);
  wire drv_on = (next_state == ST_WSETUP) || (next_state == ST_WPULSE)
    || (next_state == ST_WEND);

  // Registered pins; outputs change only from flops
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      pins <= '{addr: '0, chip_select_n: 1'b1, chip_select_high_active: 1'b0,
        write_strobe_n: 1'b1, output_enable_n: 1'b1, lower_lane_select_n: 1'b1,
        upper_lane_select_n: 1'b1};
      shared_data_bus_out <= '0;
      shared_data_bus_oe_n <= '1;
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
      retention_active <= 1'b0;
    end
    else
    begin
      pins.addr <= (take_req) ? req.addr : held.addr;
      pins.chip_select_n <= !sel_on;
      pins.chip_select_high_active <= sel_on;
      pins.write_strobe_n <= !wr_on;
      pins.output_enable_n <= !rd_on;
      pins.lower_lane_select_n <= !(sel_on && held.lanes[0]);
      pins.upper_lane_select_n <= !(sel_on && held.lanes[1]);
      shared_data_bus_out <= held.wdata;
      shared_data_bus_oe_n <= {asrbt_pkg::DATA_W{!drv_on}};
      req_ready <= (next_state == ST_IDLE) && !ret_s2;
      rsp_valid <= (state == ST_READ) && (next_state == ST_IDLE);
      if ((state == ST_READ) && (next_state == ST_IDLE))
        rsp_rdata <= sync2;
      retention_active <= (next_state == ST_RETAIN);
    end
  end

  // Assertions
  chk_write_needs_sel: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !pins.write_strobe_n |-> !pins.chip_select_n && pins.chip_select_high_active
    && !(pins.lower_lane_select_n && pins.upper_lane_select_n))
    else $error("write strobe without full select");
  chk_read_strobe_high: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !pins.output_enable_n |-> pins.write_strobe_n)
    else $error("strobe low while reading");
  chk_write_no_oe: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !pins.write_strobe_n |-> pins.output_enable_n)
    else $error("output enable low during write");
  chk_strobe_width: assert property (@(posedge sys_clk) disable iff (!reset_n)
    $fell(pins.write_strobe_n) |-> !pins.write_strobe_n [*5])
    else $error("write pulse too short");
  chk_data_before_end: assert property (@(posedge sys_clk) disable iff (!reset_n)
    $rose(pins.write_strobe_n) |-> !$past(shared_data_bus_oe_n[0], 3)
    && !shared_data_bus_oe_n[0])
    else $error("write data not held around end of write");
  chk_no_overlap: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !shared_data_bus_oe_n[0] |-> pins.output_enable_n)
    else $error("drive while memory may drive");
  chk_read_wait: assert property (@(posedge sys_clk) disable iff (!reset_n)
    $fell(pins.output_enable_n) |-> (!pins.output_enable_n) [*6])
    else $error("read access shorter than minimum");
  chk_addr_stable: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !pins.chip_select_n && !$fell(pins.chip_select_n) |-> $stable(pins.addr))
    else $error("address moved while selected");
  chk_retain_desel: assert property (@(posedge sys_clk) disable iff (!reset_n)
    retention_active |-> pins.chip_select_n)
    else $error("selected during retention");
  chk_sel_before_we: assert property (@(posedge sys_clk) disable iff (!reset_n)
    $fell(pins.write_strobe_n) |-> !$past(pins.chip_select_n))
    else $error("select not before strobe");

  cov_read: cover property (@(posedge sys_clk) disable iff (!reset_n) rsp_valid);
  cov_write: cover property (@(posedge sys_clk) disable iff (!reset_n)
    $rose(pins.write_strobe_n));
  cov_retain: cover property (@(posedge sys_clk) disable iff (!reset_n)
    $fell(retention_active));

endmodule

// File: core/asrbt_timer.sv
`timescale 1ns/1ps
module asrbt_timer
  (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic load,
  input wire logic [asrbt_pkg::CNT_W-1:0] value,
  output logic done
  );

  // Remaining cycles
  logic [asrbt_pkg::CNT_W-1:0] count;

  // Done when the count has run out and no load is pending
  assign done = (count == '0) && !load;

  // Load or count down
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
      count <= '0;
    else if (load)
      count <= value;
    else if (count != '0)
      count <= count - 4'h1;
  end

endmodule

// File: shared/asrbt_pkg.sv
package asrbt_pkg;

  // Clock period in picoseconds (125 MHz)
  localparam int unsigned CLK_PERIOD_PS = 8000;

  // Speed grade selector values
  localparam logic GRADE_FAST = 1'b0;
  localparam logic GRADE_SLOW = 1'b1;

  // Address and data widths
  localparam int unsigned ADDR_W = 20;
  localparam int unsigned DATA_W = 16;

  // Device timing figures in ns, fast grade
  localparam int unsigned READ_PERIOD_MIN_F_NS = 45;
  localparam int unsigned ADDR_TO_DATA_DELAY_F_NS = 45;
  localparam int unsigned DRIVE_TO_DATA_DELAY_F_NS = 25;
  localparam int unsigned FLOAT_DELAY_F_NS = 15;
  localparam int unsigned LANE_FLOAT_DELAY_F_NS = 20;
  localparam int unsigned WRITE_PERIOD_F_NS = 45;
  localparam int unsigned SELECT_TO_END_F_NS = 40;
  localparam int unsigned STROBE_WIDTH_F_NS = 35;
  localparam int unsigned DATA_OVERLAP_MIN_F_NS = 20;

  // Device timing figures in ns, slow grade
  localparam int unsigned READ_PERIOD_MIN_S_NS = 55;
  localparam int unsigned ADDR_TO_DATA_DELAY_S_NS = 55;
  localparam int unsigned DRIVE_TO_DATA_DELAY_S_NS = 30;
  localparam int unsigned FLOAT_DELAY_S_NS = 20;
  localparam int unsigned LANE_FLOAT_DELAY_S_NS = 25;
  localparam int unsigned WRITE_PERIOD_S_NS = 55;
  localparam int unsigned SELECT_TO_END_S_NS = 50;
  localparam int unsigned STROBE_WIDTH_S_NS = 45;
  localparam int unsigned DATA_OVERLAP_MIN_S_NS = 25;

  // Least-time conversion, rounding up, at least one cycle
  function automatic int unsigned ns_to_cyc(input int unsigned ns);
    int unsigned c;
    c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c == 0) ? 1 : c;
  endfunction

  // Cycle counts derived from the figures
  localparam int unsigned READ_CYC_F = ns_to_cyc(READ_PERIOD_MIN_F_NS);
  localparam int unsigned READ_CYC_S = ns_to_cyc(READ_PERIOD_MIN_S_NS);
  localparam int unsigned STROBE_CYC_F = ns_to_cyc(STROBE_WIDTH_F_NS);
  localparam int unsigned STROBE_CYC_S = ns_to_cyc(STROBE_WIDTH_S_NS);
  localparam int unsigned WRITE_CYC_F = ns_to_cyc(WRITE_PERIOD_F_NS);
  localparam int unsigned WRITE_CYC_S = ns_to_cyc(WRITE_PERIOD_S_NS);
  localparam int unsigned FLOAT_CYC_F = ns_to_cyc(LANE_FLOAT_DELAY_F_NS);
  localparam int unsigned FLOAT_CYC_S = ns_to_cyc(LANE_FLOAT_DELAY_S_NS);
  localparam int unsigned CNT_W = 4;

  // Pins toward the memory
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic chip_select_n;
    logic chip_select_high_active;
    logic write_strobe_n;
    logic output_enable_n;
    logic lower_lane_select_n;
    logic upper_lane_select_n;
  } asrbt_pins_t;

  // User request
  typedef struct packed {
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [1:0] lanes;
  } asrbt_req_t;

endpackage
